/* hw/ccp_compare_pwm.v */
// two-channel output compare / pwm unit with two 16-bit timebases and a wishbone register port
// assumes clk_i is the instruction clock (four oscillator periods); sleep_i and idle_i come from
// logic on clk_i; the fault inputs are asynchronous pins and are synchronised here
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ns
`include "ccp_defines.vh"

// Notes on behaviour
// - modes 110 and 111 select pwm
// - primary latch read-only in pwm, secondary written
// - timer clears on increment after period match
// - pin set at period start unless duty zero
// - duty above period keeps pin high
// - secondary copied to primary at rollover
// - period is (period+1) times prescale clk_i cycles
// - fault low in mode 111 floats pin
// - fault flag at control bit 4
// - resume needs fault released and mode rewritten
// - sleep freezes pin at its current level
// - idle runs only if both idle-stops clear
// - non-pwm compare event sets compare flag
// - compare interrupt needs flag and enable
// - pwm rollover sets only timebase flag
// - timebase select bit 3, first timer default
module ccp_compare_pwm #(
    parameter ADR_W = 12
) (
    // clock and reset
    input  wire             clk_i,
    input  wire             rst_i,
    // wishbone slave
    input  wire             cyc_i,
    input  wire             stb_i,
    input  wire             we_i,
    input  wire [ADR_W-1:0] adr_i,
    input  wire [3:0]       sel_i,
    input  wire [31:0]      dat_i,
    output wire [31:0]      dat_o,
    output wire             ack_o,
    // power state
    input  wire             sleep_i,
    input  wire             idle_i,
    // pins
    input  wire [1:0]       fault_input_pin_n_i,
    output wire [1:0]       compare_output_pin_o,
    output wire [1:0]       compare_output_pin_oe_o,
    // interrupt
    output wire             irq_o
);

    // channel state, channel i in bits [16*i +: 16] of the 32-bit registers, bit i of the 2-bit ones
    reg  [31:0] sec_reg;
    reg  [31:0] pri_reg;
    reg  [31:0] con_reg;
    reg  [1:0]  fault_flag_reg;
    reg  [1:0]  pin_reg;
    reg  [1:0]  done_reg;
    reg  [1:0]  fsync1_reg;
    reg  [1:0]  fsync2_reg;
    // timebase state
    reg  [31:0] tcnt_reg;
    reg  [31:0] tper_reg;
    reg  [31:0] tcon_reg;
    reg  [15:0] psc_reg;
    // interrupts and bus
    reg  [`CCP_IRQ_W-1:0] irq_stat_reg;
    reg  [`CCP_IRQ_W-1:0] irq_mask_reg;
    reg  [`CCP_IRQ_W-1:0] irq_stat_next;
    reg  [`CCP_IRQ_W-1:0] irq_set;
    reg  [`CCP_IRQ_W-1:0] irq_clr;
    reg         ack_reg;
    reg  [31:0] dat_reg;
    reg  [15:0] rd_data;

    // decoded writes
    reg  [1:0]  wr_sec;
    reg  [1:0]  wr_pri;
    reg  [1:0]  wr_con;
    reg  [1:0]  wr_tcnt;
    reg  [1:0]  wr_tper;
    reg  [1:0]  wr_tcon;
    reg         wr_stat;
    reg         wr_mask;

    // per-timebase and per-channel combinational events
    reg  [1:0]  trun;
    reg  [1:0]  ttick;
    reg  [1:0]  troll;
    reg  [7:0]  plim [0:1];
    reg  [1:0]  ev;
    reg  [1:0]  roll;
    reg  [1:0]  match_p;
    reg  [1:0]  match_s;
    reg  [1:0]  cmp_ev;
    reg  [1:0]  pwm_on;
    reg  [1:0]  flt_set;
    reg  [1:0]  rearm;
    reg  [15:0] wdat [0:1];

    wire [9:0]  idx   = adr_i[11:2];
    wire        req   = cyc_i & stb_i;
    wire        wr_ok = req & we_i & ack_reg;
    wire [15:0] wdata = dat_i[15:0];

    // every process owns its loop index, so no variable has two drivers
    integer     i;
    integer     t;
    integer     ts;
    integer     tk;
    integer     cj;

    // byte-lane merge of a 16-bit register
    function [15:0] merge;
        input [15:0] old_v;
        input [15:0] new_v;
        input [1:0]  lanes;
        begin
            merge = {lanes[1] ? new_v[15:8] : old_v[15:8], lanes[0] ? new_v[7:0] : old_v[7:0]};
        end
    endfunction

    // write decode
    // only the ack edge commits, so each access writes once
    always @* begin
        wr_sec  = 2'b00;
        wr_pri  = 2'b00;
        wr_con  = 2'b00;
        wr_tcnt = 2'b00;
        wr_tper = 2'b00;
        wr_tcon = 2'b00;
        wr_stat = 1'b0;
        wr_mask = 1'b0;
        if (wr_ok) begin
            case (idx)
                `CCP_IDX_SEC0:     wr_sec[0]  = 1'b1;
                `CCP_IDX_PRI0:     wr_pri[0]  = 1'b1;
                `CCP_IDX_CON0:     wr_con[0]  = 1'b1;
                `CCP_IDX_SEC1:     wr_sec[1]  = 1'b1;
                `CCP_IDX_PRI1:     wr_pri[1]  = 1'b1;
                `CCP_IDX_CON1:     wr_con[1]  = 1'b1;
                `CCP_IDX_TCNT0:    wr_tcnt[0] = 1'b1;
                `CCP_IDX_TPER0:    wr_tper[0] = 1'b1;
                `CCP_IDX_TCON0:    wr_tcon[0] = 1'b1;
                `CCP_IDX_TCNT1:    wr_tcnt[1] = 1'b1;
                `CCP_IDX_TPER1:    wr_tper[1] = 1'b1;
                `CCP_IDX_TCON1:    wr_tcon[1] = 1'b1;
                `CCP_IDX_IRQ_STAT: wr_stat    = 1'b1;
                `CCP_IDX_IRQ_MASK: wr_mask    = 1'b1;
                default:           wr_stat    = 1'b0;
            endcase
        end
    end

    // read mux; unmapped indices read as zero
    always @* begin
        case (idx)
            `CCP_IDX_SEC0:     rd_data = sec_reg[15:0];
            `CCP_IDX_PRI0:     rd_data = pri_reg[15:0];
            `CCP_IDX_CON0:     rd_data = con_reg[15:0] | {11'h000, fault_flag_reg[0], 4'h0};
            `CCP_IDX_SEC1:     rd_data = sec_reg[31:16];
            `CCP_IDX_PRI1:     rd_data = pri_reg[31:16];
            `CCP_IDX_CON1:     rd_data = con_reg[31:16] | {11'h000, fault_flag_reg[1], 4'h0};
            `CCP_IDX_TCNT0:    rd_data = tcnt_reg[15:0];
            `CCP_IDX_TPER0:    rd_data = tper_reg[15:0];
            `CCP_IDX_TCON0:    rd_data = tcon_reg[15:0];
            `CCP_IDX_TCNT1:    rd_data = tcnt_reg[31:16];
            `CCP_IDX_TPER1:    rd_data = tper_reg[31:16];
            `CCP_IDX_TCON1:    rd_data = tcon_reg[31:16];
            `CCP_IDX_IRQ_STAT: rd_data = {10'h000, irq_stat_reg};
            `CCP_IDX_IRQ_MASK: rd_data = {10'h000, irq_mask_reg};
            default:           rd_data = 16'h0000;
        endcase
    end

    // timebase events: one increment per clk_i, i.e. four oscillator periods, times prescale
    always @* begin
        for (t = 0; t < 2; t = t + 1) begin
            // prescale 1, 8, 64 or 256 clk_i cycles per increment
            case (tcon_reg[16*t+`CCP_TCON_PS_LSB +: 2])
                2'h0:    plim[t] = `CCP_PS_LIM1;
                2'h1:    plim[t] = `CCP_PS_LIM8;
                2'h2:    plim[t] = `CCP_PS_LIM64;
                default: plim[t] = `CCP_PS_LIM256;
            endcase
            // sleep stops every timebase, idle only one with its idle-stop bit set
            trun[t]  = tcon_reg[16*t+`CCP_TCON_ON] & ~sleep_i &
                       ~(idle_i & tcon_reg[16*t+`CCP_TCON_IDLE_STOP]);
            ttick[t] = trun[t] & (psc_reg[8*t +: 8] == plim[t]);
            troll[t] = ttick[t] & (tcnt_reg[16*t +: 16] == tper_reg[16*t +: 16]);
        end
    end

    // channel events
    always @* begin
        irq_set = `CCP_RST_IRQ;
        irq_clr = `CCP_RST_IRQ;
        if (wr_stat) begin
            irq_clr = wdata[`CCP_IRQ_W-1:0];
        end
        for (i = 0; i < 2; i = i + 1) begin
            ts         = con_reg[16*i+`CCP_CON_TSEL] ? 1 : 0;
            wdat[i]    = merge(con_reg[16*i +: 16], wdata, sel_i[1:0]);
            pwm_on[i]  = (con_reg[16*i +: 3] == `CCP_MODE_PWM) ||
                         (con_reg[16*i +: 3] == `CCP_MODE_PWM_FLT);
            ev[i]      = ttick[ts] & ~(idle_i & con_reg[16*i+`CCP_CON_IDLE_STOP]);
            roll[i]    = ev[i] & troll[ts];
            match_p[i] = ev[i] & (tcnt_reg[16*ts +: 16] == pri_reg[16*i +: 16]);
            match_s[i] = ev[i] & (tcnt_reg[16*ts +: 16] == sec_reg[16*i +: 16]);
            case (con_reg[16*i +: 3])
                `CCP_MODE_LOW,
                `CCP_MODE_HIGH,
                `CCP_MODE_TOGGLE: cmp_ev[i] = match_p[i];
                `CCP_MODE_SINGLE: cmp_ev[i] = match_s[i] & ~done_reg[i];
                `CCP_MODE_CONT:   cmp_ev[i] = match_s[i];
                default:          cmp_ev[i] = 1'b0;
            endcase
            flt_set[i] = (con_reg[16*i +: 3] == `CCP_MODE_PWM_FLT) & ~fsync2_reg[i];
            // a fault clears only with the pin back high and a pwm mode rewritten
            rearm[i]   = wr_con[i] & (wdat[i][2:1] == 2'b11) & fsync2_reg[i];
            irq_set[`CCP_IRQ_CMP_LSB+i] = cmp_ev[i];
            irq_set[`CCP_IRQ_FLT_LSB+i] = flt_set[i] & ~fault_flag_reg[i];
        end
        irq_set[`CCP_IRQ_TB_LSB +: 2] = troll;
        // set wins over a clear in the same cycle
        irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;
    end

    // bus handshake: ack one cycle after the request, read data with it
    // a held request is answered every second cycle; the master must drop it after the ack
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h00000000;
        end else begin
            ack_reg <= req & ~ack_reg;
            if (req & ~ack_reg) begin
                dat_reg <= {16'h0000, rd_data};
            end
        end
    end

    // fault pin synchroniser
    // resets to the released (high) level, so no false fault follows reset
    always @(posedge clk_i) begin
        if (rst_i) begin
            fsync1_reg <= 2'b11;
            fsync2_reg <= 2'b11;
        end else begin
            fsync1_reg <= fault_input_pin_n_i;
            fsync2_reg <= fsync1_reg;
        end
    end

    // timebases; a sleeping device takes no tick so everything holds
    always @(posedge clk_i) begin
        if (rst_i) begin
            tcnt_reg <= 32'h00000000;
            tper_reg <= 32'hFFFFFFFF;
            tcon_reg <= 32'h00000000;
            psc_reg  <= 16'h0000;
        end else begin
            for (tk = 0; tk < 2; tk = tk + 1) begin
                if (trun[tk]) begin
                    psc_reg[8*tk +: 8] <= ttick[tk] ? 8'h00 : psc_reg[8*tk +: 8] + 8'h01;
                end
                if (troll[tk]) begin
                    tcnt_reg[16*tk +: 16] <= 16'h0000;
                end else if (ttick[tk]) begin
                    tcnt_reg[16*tk +: 16] <= tcnt_reg[16*tk +: 16] + 16'h0001;
                end
                // a software count write comes last, so it wins over the increment
                if (wr_tcnt[tk]) begin
                    tcnt_reg[16*tk +: 16] <= merge(tcnt_reg[16*tk +: 16], wdata, sel_i[1:0]);
                end
                if (wr_tper[tk]) begin
                    tper_reg[16*tk +: 16] <= merge(tper_reg[16*tk +: 16], wdata, sel_i[1:0]);
                end
                if (wr_tcon[tk]) begin
                    tcon_reg[16*tk +: 16] <= merge(tcon_reg[16*tk +: 16], wdata, sel_i[1:0]) & `CCP_TCON_WMASK;
                    psc_reg[8*tk +: 8]    <= 8'h00;
                end
            end
        end
    end

    // channels
    always @(posedge clk_i) begin
        if (rst_i) begin
            sec_reg        <= 32'h00000000;
            pri_reg        <= 32'h00000000;
            con_reg        <= 32'h00000000;
            fault_flag_reg <= 2'b00;
            pin_reg        <= 2'b00;
            done_reg       <= 2'b00;
        end else begin
            for (cj = 0; cj < 2; cj = cj + 1) begin
                if (wr_sec[cj]) begin
                    sec_reg[16*cj +: 16] <= merge(sec_reg[16*cj +: 16], wdata, sel_i[1:0]);
                end
                if (wr_pri[cj] && !pwm_on[cj]) begin
                    pri_reg[16*cj +: 16] <= merge(pri_reg[16*cj +: 16], wdata, sel_i[1:0]);
                end
                if (wr_con[cj]) begin
                    con_reg[16*cj +: 16] <= wdat[cj] & `CCP_CON_WMASK;
                    done_reg[cj]         <= 1'b0;
                end
                if (rearm[cj]) begin
                    fault_flag_reg[cj] <= 1'b0;
                end
                if (flt_set[cj]) begin
                    fault_flag_reg[cj] <= 1'b1;
                end
                // pwm: period start sets the pin, a duty match clears it
                if (pwm_on[cj]) begin
                    if (roll[cj]) begin
                        pri_reg[16*cj +: 16] <= sec_reg[16*cj +: 16];
                        pin_reg[cj]          <= (sec_reg[16*cj +: 16] != 16'h0000);
                    end else if (match_p[cj]) begin
                        pin_reg[cj] <= 1'b0;
                    end
                end else begin
                    case (con_reg[16*cj +: 3])
                        `CCP_MODE_LOW: begin
                            if (match_p[cj]) pin_reg[cj] <= 1'b0;
                        end
                        `CCP_MODE_HIGH: begin
                            if (match_p[cj]) pin_reg[cj] <= 1'b1;
                        end
                        `CCP_MODE_TOGGLE: begin
                            if (match_p[cj]) pin_reg[cj] <= ~pin_reg[cj];
                        end
                        `CCP_MODE_SINGLE: begin
                            if (match_p[cj] && !done_reg[cj]) pin_reg[cj] <= 1'b1;
                            if (match_s[cj]) begin
                                pin_reg[cj]  <= 1'b0;
                                done_reg[cj] <= 1'b1;
                            end
                        end
                        `CCP_MODE_CONT: begin
                            if (match_p[cj]) pin_reg[cj] <= 1'b1;
                            if (match_s[cj]) pin_reg[cj] <= 1'b0;
                        end
                        default: pin_reg[cj] <= 1'b0;
                    endcase
                end
            end
            // sleep_i stops every tick so pin_reg keeps its level
        end
    end

    // interrupt registers
    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_reg <= `CCP_RST_IRQ;
            irq_mask_reg <= `CCP_RST_IRQ;
        end else begin
            irq_stat_reg <= irq_stat_next;
            if (wr_mask) begin
                irq_mask_reg <= wdata[`CCP_IRQ_W-1:0];
            end
        end
    end

    // a pin is released while its channel is off or a fault holds it
    assign dat_o                   = dat_reg;
    assign ack_o                   = ack_reg;
    assign compare_output_pin_o    = pin_reg;
    assign compare_output_pin_oe_o = ~fault_flag_reg &
                                     {con_reg[18:16] != `CCP_MODE_OFF, con_reg[2:0] != `CCP_MODE_OFF};
    assign irq_o                   = |(irq_stat_reg & irq_mask_reg);

endmodule

/* hw/ccp_defines.vh */
// register indices, field positions, reset values and timing figures of the compare/pwm block
// assumes a 32-bit classic wishbone slave; byte address = 4 * register index
`ifndef CCP_DEFINES_VH
`define CCP_DEFINES_VH

// register indices (byte address is four times the index)
`define CCP_IDX_SEC0        10'h180
`define CCP_IDX_PRI0        10'h182
`define CCP_IDX_CON0        10'h184
`define CCP_IDX_SEC1        10'h186
`define CCP_IDX_PRI1        10'h188
`define CCP_IDX_CON1        10'h18A
`define CCP_IDX_TCNT0       10'h1A0
`define CCP_IDX_TPER0       10'h1A2
`define CCP_IDX_TCON0       10'h1A4
`define CCP_IDX_TCNT1       10'h1A6
`define CCP_IDX_TPER1       10'h1A8
`define CCP_IDX_TCON1       10'h1AA
`define CCP_IDX_IRQ_STAT    10'h1AC
`define CCP_IDX_IRQ_MASK    10'h1AE

// channel control fields
`define CCP_CON_MODE_LSB    0
`define CCP_CON_TSEL        3
`define CCP_CON_FAULT       4
`define CCP_CON_IDLE_STOP   13
`define CCP_CON_FREEZE      14
`define CCP_CON_WMASK       16'h600F

// channel mode encodings
`define CCP_MODE_OFF        3'h0
`define CCP_MODE_LOW        3'h1
`define CCP_MODE_HIGH       3'h2
`define CCP_MODE_TOGGLE     3'h3
`define CCP_MODE_SINGLE     3'h4
`define CCP_MODE_CONT       3'h5
`define CCP_MODE_PWM        3'h6
`define CCP_MODE_PWM_FLT    3'h7

// timebase control fields
`define CCP_TCON_ON         15
`define CCP_TCON_IDLE_STOP  13
`define CCP_TCON_PS_LSB     4
`define CCP_TCON_WMASK      16'hA030

// interrupt status / mask layout
`define CCP_IRQ_CMP_LSB     0
`define CCP_IRQ_TB_LSB      2
`define CCP_IRQ_FLT_LSB     4
`define CCP_IRQ_W           6

// prescale terminal counts (divide by 1, 8, 64, 256)
`define CCP_PS_LIM1         8'h00
`define CCP_PS_LIM8         8'h07
`define CCP_PS_LIM64        8'h3F
`define CCP_PS_LIM256       8'hFF

// reset values
`define CCP_RST_16          16'h0000
`define CCP_RST_IRQ         6'h00

// at prescale 1, one timer increment is four oscillator periods (one clk_i cycle)
`define CCP_OSC_PER_INC     4

`endif

/* sim/ccp_pwm_properties.sv */
// concurrent checks on the ports of the compare/pwm unit
// bound into ccp_compare_pwm; one clock, synchronous reset
`timescale 1ns/1ns
module ccp_pwm_properties #(
    parameter ADR_W = 12
) (
    // clock and reset
    input wire             clk_i,
    input wire             rst_i,
    // bus
    input wire             cyc_i,
    input wire             stb_i,
    input wire             we_i,
    input wire [ADR_W-1:0] adr_i,
    input wire [3:0]       sel_i,
    input wire [31:0]      dat_i,
    input wire [31:0]      dat_o,
    input wire             ack_o,
    // power state, pins, interrupt
    input wire             sleep_i,
    input wire             idle_i,
    input wire [1:0]       fault_input_pin_n_i,
    input wire [1:0]       compare_output_pin_o,
    input wire [1:0]       compare_output_pin_oe_o,
    input wire             irq_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_ack_one_cycle: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_ack_answer: assert property ($rose(cyc_i && stb_i) |=> ack_o)
        else $error("no ack one cycle after request");
    a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    a_read_upper: assert property (ack_o && !we_i |-> dat_o[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    a_sleep_pin_hold: assert property (sleep_i && $past(sleep_i) |-> $stable(compare_output_pin_o))
        else $error("pin moved during sleep");
    a_oe_rise_write: assert property ($rose(compare_output_pin_oe_o[0]) || $rose(compare_output_pin_oe_o[1])
        |-> $past(ack_o && we_i))
        else $error("pin drive resumed without a register write");
    a_oe_fall_cause: assert property ($fell(compare_output_pin_oe_o[1]) |-> $past(ack_o && we_i)
        || !$past(fault_input_pin_n_i[1]) || !$past(fault_input_pin_n_i[1], 2)
        || !$past(fault_input_pin_n_i[1], 3) || !$past(fault_input_pin_n_i[1], 4))
        else $error("pin released without fault or write");
    a_irq_fall_write: assert property ($fell(irq_o) |-> $past(ack_o && we_i))
        else $error("interrupt dropped without a register write");
endmodule

bind ccp_compare_pwm ccp_pwm_properties #(.ADR_W(ADR_W)) u_ccp_pwm_properties (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .sleep_i(sleep_i), .idle_i(idle_i),
    .fault_input_pin_n_i(fault_input_pin_n_i), .compare_output_pin_o(compare_output_pin_o),
    .compare_output_pin_oe_o(compare_output_pin_oe_o), .irq_o(irq_o));

/* sim/ccp_power_stage.sv */
// model of the power stage fed by the two compare pins
// assumes pull-downs on its pin inputs; fault lines change after clk_i edges
`timescale 1ns/1ns
module ccp_power_stage (
    // clock
    input  wire       clk_i,
    // pins from the unit
    input  wire [1:0] pin_i,
    input  wire [1:0] oe_i,
    // overload requests from the bench
    input  wire [1:0] trip_i,
    // fault lines and sensed levels
    output reg  [1:0] fault_input_pin_n_o,
    output wire [1:0] line_o
);
    // a released pin reads as the pull-down level
    assign line_o = pin_i & oe_i;
    initial fault_input_pin_n_o = 2'h3;
    // fault stays low until the overload is removed
    always @(posedge clk_i) begin
        fault_input_pin_n_o <= ~trip_i;
    end
endmodule

/* sim/tb.sv */
// self-checking bench for the compare/pwm unit
// assumes the power stage model and the bound property checker
`timescale 1ns/1ns
`include "ccp_defines.vh"
module tb;
    logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, sleep_i = 0, idle_i = 0;
    logic [11:0] adr_i = 12'h000;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, rd;
    logic [1:0]  trip = 2'h0;
    wire  [31:0] dat_o;
    wire         ack_o, irq_o;
    wire  [1:0]  pin, oe, flt_n, line;
    int          n_fail = 0, checks_done = 0, cyc_cnt = 0, per, hi;
    logic [9:0]  r_idx [7] = '{`CCP_IDX_SEC0, `CCP_IDX_PRI0, `CCP_IDX_CON0, `CCP_IDX_PRI0, `CCP_IDX_TCON0,
                               `CCP_IDX_IRQ_MASK, 10'h1FF};
    logic [15:0] r_wr  [7] = '{16'hA5A5, 16'h1234, 16'hFFFF, 16'h5555, 16'hFFFF, 16'hFFFF, 16'h1234};
    logic [15:0] r_exp [7] = '{16'hA5A5, 16'h1234, 16'h600F, 16'h1234, 16'hA030, 16'h003F, 16'h0000};
    logic [15:0] p_per [3] = '{16'h0003, 16'h0003, 16'h0005};
    logic [15:0] p_sec [3] = '{16'h0002, 16'h0002, 16'h0001};
    logic [15:0] p_ton [3] = '{16'h8000, 16'h8010, 16'h8000};
    int          p_len [3] = '{4, 32, 6};
    int          p_hi  [3] = '{3, 24, 2};

    ccp_compare_pwm u_ccp_compare_pwm (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .sleep_i(sleep_i), .idle_i(idle_i), .fault_input_pin_n_i(flt_n), .compare_output_pin_o(pin),
        .compare_output_pin_oe_o(oe), .irq_o(irq_o));
    ccp_power_stage u_ccp_power_stage (.clk_i(clk_i), .pin_i(pin), .oe_i(oe), .trip_i(trip),
        .fault_input_pin_n_o(flt_n), .line_o(line));

    initial forever #20 clk_i = ~clk_i;

    task give_verdict;
        $display("mismatches %0d, checks %0d", n_fail, checks_done);
        if (n_fail == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            n_fail++;
            give_verdict;
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task wb(input logic w, input logic [9:0] a, input logic [15:0] d);
        @(posedge clk_i);
        cyc_i <= 1'h1;
        stb_i <= 1'h1;
        we_i  <= w;
        adr_i <= {a, 2'h0};
        sel_i <= 4'h3;
        dat_i <= {16'h0000, d};
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'h1);
        rd = dat_o;
        cyc_i <= 1'h0;
        stb_i <= 1'h0;
        we_i  <= 1'h0;
    endtask

    task do_reset;
        @(posedge clk_i);
        rst_i <= 1'h1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
    endtask

    // one period from rising edge to rising edge of the sensed line
    task meas(input int c);
        logic p;
        p = 1'h1;
        per = 0;
        hi = 0;
        while (!(p == 1'h0 && line[c] == 1'h1) && per < 600) begin
            p = line[c];
            @(negedge clk_i);
            per++;
        end
        per = 0;
        do begin
            hi += line[c];
            per++;
            p = line[c];
            @(negedge clk_i);
        end while (!(p == 1'h0 && line[c] == 1'h1) && per < 600);
    endtask

    task hold(input int c, input logic v, input int n);
        repeat (n) begin
            @(negedge clk_i);
            chk({31'h0, line[c]}, {31'h0, v});
        end
    endtask

    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        for (int i = 0; i < 7; i++) begin
            wb(1'h1, r_idx[i], r_wr[i]);
            wb(1'h0, r_idx[i], 16'h0000);
            chk(rd, {16'h0000, r_exp[i]});
        end
        do_reset;
        @(negedge clk_i);
        chk({27'h0, pin, oe, irq_o}, 32'h0);
        for (int i = 0; i < 6; i++) begin
            wb(1'h0, `CCP_IDX_SEC0 + 10'(2 * i), 16'h0000);
            chk(rd, 32'h0);
        end
        wb(1'h0, `CCP_IDX_TPER0, 16'h0000);
        chk(rd, 32'h0000FFFF);
        for (int i = 0; i < 3; i++) begin
            wb(1'h1, `CCP_IDX_TCON0, 16'h0000);
            wb(1'h1, `CCP_IDX_TCNT0, 16'h0000);
            wb(1'h1, `CCP_IDX_TPER0, p_per[i]);
            wb(1'h1, `CCP_IDX_SEC0, p_sec[i]);
            wb(1'h1, `CCP_IDX_CON0, 16'h0006);
            wb(1'h1, `CCP_IDX_TCON0, p_ton[i]);
            meas(0);
            chk(per, p_len[i]);
            chk(hi, p_hi[i]);
        end
        wb(1'h1, `CCP_IDX_PRI0, 16'h7777);
        wb(1'h0, `CCP_IDX_PRI0, 16'h0000);
        chk(rd, 32'h1);
        wb(1'h1, `CCP_IDX_SEC0, 16'h0000);
        repeat (14) @(negedge clk_i);
        hold(0, 1'h0, 12);
        wb(1'h1, `CCP_IDX_SEC0, 16'h0009);
        repeat (14) @(negedge clk_i);
        hold(0, 1'h1, 12);
        wb(1'h1, `CCP_IDX_SEC0, 16'h0002);
        meas(0);
        @(posedge clk_i);
        sleep_i <= 1'h1;
        hold(0, 1'h1, 40);
        @(posedge clk_i);
        sleep_i <= 1'h0;
        meas(0);
        chk(per, 6);
        @(posedge clk_i);
        idle_i <= 1'h1;
        meas(0);
        chk(per, 6);
        wb(1'h1, `CCP_IDX_TCON0, 16'hA000);
        wb(1'h1, `CCP_IDX_TCNT0, 16'h0001);
        repeat (10) @(posedge clk_i);
        wb(1'h0, `CCP_IDX_TCNT0, 16'h0000);
        chk(rd, 32'h1);
        idle_i <= 1'h0;
        wb(1'h1, `CCP_IDX_TCON0, 16'h8000);
        wb(1'h0, `CCP_IDX_IRQ_STAT, 16'h0000);
        chk(rd, 32'h4);
        chk({31'h0, irq_o}, 32'h0);
        wb(1'h1, `CCP_IDX_IRQ_MASK, 16'h0004);
        @(negedge clk_i);
        chk({31'h0, irq_o}, 32'h1);
        wb(1'h1, `CCP_IDX_TCON0, 16'h0000);
        wb(1'h1, `CCP_IDX_IRQ_STAT, 16'h0004);
        @(negedge clk_i);
        chk({31'h0, irq_o}, 32'h0);
        wb(1'h1, `CCP_IDX_CON0, 16'h0001);
        wb(1'h1, `CCP_IDX_PRI0, 16'h0002);
        wb(1'h1, `CCP_IDX_TCON0, 16'h8000);
        repeat (20) @(posedge clk_i);
        wb(1'h0, `CCP_IDX_IRQ_STAT, 16'h0000);
        chk(rd & 32'h1, 32'h1);
        wb(1'h1, `CCP_IDX_CON0, 16'h0003);
        meas(0);
        chk(per, 12);
        chk(hi, 6);
        wb(1'h1, `CCP_IDX_CON0, 16'h0001);
        repeat (8) @(negedge clk_i);
        hold(0, 1'h0, 4);
        wb(1'h1, `CCP_IDX_CON0, 16'h0002);
        repeat (8) @(negedge clk_i);
        hold(0, 1'h1, 4);
        wb(1'h1, `CCP_IDX_PRI0, 16'h0001);
        wb(1'h1, `CCP_IDX_SEC0, 16'h0003);
        wb(1'h1, `CCP_IDX_CON0, 16'h0005);
        meas(0);
        chk(per, 6);
        chk(hi, 2);
        wb(1'h1, `CCP_IDX_TCON0, 16'h0000);
        wb(1'h1, `CCP_IDX_TCNT0, 16'h0000);
        wb(1'h1, `CCP_IDX_CON0, 16'h0004);
        wb(1'h1, `CCP_IDX_TCON0, 16'h8000);
        hi = 0;
        repeat (30) begin
            @(negedge clk_i);
            hi += line[0];
        end
        chk(hi, 2);
        wb(1'h1, `CCP_IDX_TPER1, 16'h0003);
        wb(1'h1, `CCP_IDX_SEC1, 16'h0001);
        wb(1'h1, `CCP_IDX_CON1, 16'h000F);
        wb(1'h1, `CCP_IDX_TCON1, 16'h8000);
        meas(1);
        chk(per, 4);
        chk(hi, 2);
        @(posedge clk_i);
        trip <= 2'h2;
        repeat (6) @(negedge clk_i);
        chk({31'h0, oe[1]}, 32'h0);
        wb(1'h0, `CCP_IDX_CON1, 16'h0000);
        chk(rd, 32'h001F);
        wb(1'h1, `CCP_IDX_CON1, 16'h000F);
        @(negedge clk_i);
        chk({31'h0, oe[1]}, 32'h0);
        @(posedge clk_i);
        trip <= 2'h0;
        repeat (6) @(negedge clk_i);
        chk({31'h0, oe[1]}, 32'h0);
        wb(1'h1, `CCP_IDX_CON1, 16'h000F);
        @(negedge clk_i);
        chk({31'h0, oe[1]}, 32'h1);
        give_verdict;
    end
endmodule
